/* File: inc/ewc_pkg.sv */
// Shared constants and types for the data EEPROM write controller.
// Assumes a single 40 MHz clock and a byte-wide CPU data-space bus.
`default_nettype none

package ewc_pkg;

   // ---------------------------------------------
   // Control register
   // ---------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hEA;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int STANDBY_POS = 6;
   localparam int PSTART_POS = 3;
   localparam int PMODE_POS = 2;
   localparam int BUSY_POS = 1;
   localparam int PENABLE_POS = 0;

   // ---------------------------------------------
   // Array geometry
   // ---------------------------------------------
   localparam logic [7:0] WINDOW_TOP = 8'h3F;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [1:0] PAGE0_SEL = 2'h1;
   localparam logic [1:0] PAGE1_SEL = 2'h2;
   localparam int ROW_BYTES = 8;
   localparam int ARRAY_DEPTH = 128;

   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 5000;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COUNT_W = 16;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ewc_bus_t;

   typedef enum logic {EWC_IDLE, EWC_PROG} ewc_state_t;

   typedef logic [ROW_BYTES-1:0][7:0] ewc_row_t;

endpackage

`default_nettype wire

/* File: rtl/ewc_reset_sync.sv */
// Reset synchroniser: async assert, release through two flip-flops.
// Assumes rstn may be released at any time relative to clk.
`default_nettype none

module ewc_reset_sync (
   input wire logic clk,
   input wire logic rstn,
   output logic rstnSync
);

   logic stage_reg;
   logic stage_next;
   logic out_next;

   // ---------------------------------------------
   // Two-stage release
   // ---------------------------------------------
   always_comb begin
      stage_next = 1'b1;
      out_next = stage_reg;
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage_reg <= 1'b0;
         rstnSync <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         rstnSync <= out_next;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/ewc_row_latch.sv */
// Volatile row latches: eight data bytes with a loaded mask.
// Assumes the owner raises clear and load in the same cycle to restart a row.
`default_nettype none

module ewc_row_latch (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic load,
   input wire logic [2:0] index,
   input wire logic [7:0] data,
   output ewc_pkg::ewc_row_t rowData,
   output logic [ewc_pkg::ROW_BYTES-1:0] rowMask
);

   // ---------------------------------------------
   // One latch per row byte
   // ---------------------------------------------
   for (genvar i = 0; i < ewc_pkg::ROW_BYTES; i++) begin : gEntry
      logic hit;
      logic [7:0] data_next;
      logic mask_next;

      assign hit = load && (index == 3'(i));

      // A load in a clearing cycle still lands, so clear then load works
      always_comb begin
         data_next = rowData[i];
         mask_next = clear ? 1'b0 : rowMask[i];
         if (hit) begin
            data_next = data;
            mask_next = 1'b1;
         end
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rowData[i] <= 8'h00;
            rowMask[i] <= 1'b0;
         end else begin
            rowData[i] <= data_next;
            rowMask[i] <= mask_next;
         end
      end
   end

endmodule

`default_nettype wire

/* File: rtl/ewc_top.sv */
// Data EEPROM write controller: control register, row latches and array.
// Assumes a CPU data-space bus synchronous to clk and a separate bank register.
//
// Function
// [R01] Control register at EAh, written as a whole, resets to 00h.
// [R02] Standby bit 6 disables the array, voids accesses, minimises power.
// [R03] Writing start bit 3 in parallel mode programs the loaded row bytes.
// [R04] Start bit clears itself when programming finishes.
// [R05] Row bytes not loaded keep their old contents.
// [R06] Parallel mode bit 2 set, start clear: up to eight row bytes load.
// [R07] Address bits 6..3 fix the row, bits 2..0 pick the byte.
// [R08] Parallel mode bit clears itself at the end of programming.
// [R09] Clearing parallel mode before start drops the row, array untouched.
// [R10] Busy bit 1 reads high throughout a programming cycle.
// [R11] Accesses while busy are aborted; the running cycle completes.
// [R12] Software polls busy clear before any array access.
// [R13] With enable bit 0 clear, array writes are ignored, no cycle starts.
// [R14] Software sets the enable bit before writing the array.
// [R15] Unprogrammed array bytes read FFh.
// [R16] Setting parallel mode clears all row latches and holds the row address.
// [R17] Start sets only when enable and parallel mode are already set.
// [R18] While busy, control writes are ignored; only busy may be read.
// [R19] Programming time is a block parameter in clock cycles; busy spans it.
// [R20] Write-only bits and bit 7 read zero; only busy is live.
`default_nettype none

module ewc_top #(
   parameter int PROG_CYCLES = ewc_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire ewc_pkg::ewc_bus_t cpuBus,
   input wire logic [1:0] dataBankSelect,
   output logic [7:0] rdata,
   output logic eepromBusy,
   output logic eepromStandby
);

   localparam int PROG_LEN = PROG_CYCLES;

   // ---------------------------------------------
   // Reset release
   // ---------------------------------------------
   logic rstnSync;

   ewc_reset_sync uResetSync (
      .clk(clk),
      .rstn(rstn),
      .rstnSync(rstnSync)
   );

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   ewc_pkg::ewc_state_t state_reg, state_next;
   logic [ewc_pkg::COUNT_W-1:0] count_reg, count_next;
   logic standby_reg, standby_next;
   logic enable_reg, enable_next;
   logic pmode_reg, pmode_next;
   logic pstart_reg, pstart_next;
   logic rowHeld_reg, rowHeld_next;
   logic [3:0] row_reg, row_next;
   logic busy_reg, busy_next;
   logic [7:0] rdata_next;
   logic [7:0] cells_reg [ewc_pkg::ARRAY_DEPTH];
   logic [7:0] cells_next [ewc_pkg::ARRAY_DEPTH];

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   logic ctrlWr;
   logic ctrlRd;
   logic bankOk;
   logic eeSel;
   logic eeOk;
   logic eeWr;
   logic [6:0] eeAddr;
   logic latchClear;
   logic latchLoad;
   logic commit;
   ewc_pkg::ewc_row_t rowData;
   logic [ewc_pkg::ROW_BYTES-1:0] rowMask;

   // Exactly one page bit must be set, else the window maps nothing
   assign ctrlWr = cpuBus.wr && (cpuBus.addr == ewc_pkg::CTRL_ADDR); // [R01]
   assign ctrlRd = cpuBus.rd && (cpuBus.addr == ewc_pkg::CTRL_ADDR);
   assign bankOk = (dataBankSelect == ewc_pkg::PAGE0_SEL) ||
                   (dataBankSelect == ewc_pkg::PAGE1_SEL);
   assign eeSel = (cpuBus.addr <= ewc_pkg::WINDOW_TOP) && bankOk;
   assign eeOk = eeSel && !standby_reg && !busy_reg; // [R02] [R11]
   assign eeWr = cpuBus.wr && eeOk;
   assign eeAddr = {dataBankSelect[1], cpuBus.addr[5:0]};

   // ---------------------------------------------
   // Row latches
   // ---------------------------------------------
   ewc_row_latch uRowLatch (
      .clk(clk),
      .rstn(rstnSync),
      .clear(latchClear),
      .load(latchLoad),
      .index(eeAddr[2:0]), // [R07]
      .data(cpuBus.wdata),
      .rowData(rowData),
      .rowMask(rowMask)
   );

   // ---------------------------------------------
   // Control sequencing
   // ---------------------------------------------
   // Control writes are only looked at in idle, so busy locks the register
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      standby_next = standby_reg;
      enable_next = enable_reg;
      pmode_next = pmode_reg;
      pstart_next = pstart_reg;
      rowHeld_next = rowHeld_reg;
      row_next = row_reg;
      latchClear = 1'b0;
      latchLoad = 1'b0;
      commit = 1'b0;
      case (state_reg)
         ewc_pkg::EWC_IDLE: begin
            if (ctrlWr) begin
               standby_next = cpuBus.wdata[ewc_pkg::STANDBY_POS]; // [R02]
               enable_next = cpuBus.wdata[ewc_pkg::PENABLE_POS];
               pmode_next = cpuBus.wdata[ewc_pkg::PMODE_POS];
               // Entering or leaving parallel mode empties the row
               if (!pmode_reg || !cpuBus.wdata[ewc_pkg::PMODE_POS]) begin
                  latchClear = 1'b1; // [R16] [R09]
                  rowHeld_next = 1'b0;
               end
               if (cpuBus.wdata[ewc_pkg::PSTART_POS] && cpuBus.wdata[ewc_pkg::PMODE_POS] &&
                   enable_reg && pmode_reg) begin // [R17]
                  pstart_next = 1'b1; // [R03]
                  state_next = ewc_pkg::EWC_PROG;
                  count_next = ewc_pkg::COUNT_W'(PROG_CYCLES - 1); // [R19]
               end
            end else if (eeWr && enable_reg) begin // [R13]
               if (pmode_reg) begin
                  // Writes outside the held row are dropped
                  if (!rowHeld_reg || (eeAddr[6:3] == row_reg)) begin // [R07]
                     latchLoad = 1'b1; // [R06]
                     rowHeld_next = 1'b1;
                     row_next = eeAddr[6:3]; // [R16]
                  end
               end else begin
                  // Byte mode reuses the latch as a one-byte row
                  latchClear = 1'b1;
                  latchLoad = 1'b1;
                  row_next = eeAddr[6:3];
                  state_next = ewc_pkg::EWC_PROG;
                  count_next = ewc_pkg::COUNT_W'(PROG_CYCLES - 1); // [R19]
               end
            end
         end
         ewc_pkg::EWC_PROG: begin // [R18] Control writes are not decoded here
            if (count_reg == '0) begin
               commit = 1'b1;
               state_next = ewc_pkg::EWC_IDLE;
               pstart_next = 1'b0; // [R04]
               pmode_next = 1'b0; // [R08]
               rowHeld_next = 1'b0;
               latchClear = 1'b1;
            end else begin
               count_next = count_reg - 1'b1; // [R11]
            end
         end
         default: begin
            state_next = ewc_pkg::EWC_IDLE;
         end
      endcase
   end

   // Busy mirrors the sequencer so reads see it in the same cycle
   assign busy_next = (state_next == ewc_pkg::EWC_PROG); // [R10]

   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         state_reg <= ewc_pkg::EWC_IDLE;
         count_reg <= '0;
         standby_reg <= ewc_pkg::CTRL_RESET[ewc_pkg::STANDBY_POS]; // [R01]
         enable_reg <= ewc_pkg::CTRL_RESET[ewc_pkg::PENABLE_POS];
         pmode_reg <= ewc_pkg::CTRL_RESET[ewc_pkg::PMODE_POS];
         pstart_reg <= ewc_pkg::CTRL_RESET[ewc_pkg::PSTART_POS];
         busy_reg <= ewc_pkg::CTRL_RESET[ewc_pkg::BUSY_POS];
         rowHeld_reg <= 1'b0;
         row_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         standby_reg <= standby_next;
         enable_reg <= enable_next;
         pmode_reg <= pmode_next;
         pstart_reg <= pstart_next;
         busy_reg <= busy_next;
         rowHeld_reg <= rowHeld_next;
         row_reg <= row_next;
      end
   end

   // ---------------------------------------------
   // Cell array
   // ---------------------------------------------
   // Only loaded bytes are written; the rest of the row is left alone
   always_comb begin
      cells_next = cells_reg;
      if (commit) begin
         for (int i = 0; i < ewc_pkg::ROW_BYTES; i++) begin
            if (rowMask[i]) begin // [R05]
               cells_next[{row_reg, 3'(i)}] = rowData[i];
            end
         end
      end
   end

   // Reset stands in for the erased state of a fresh part
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         for (int i = 0; i < ewc_pkg::ARRAY_DEPTH; i++) begin
            cells_reg[i] <= ewc_pkg::ERASED_BYTE; // [R15]
         end
      end else begin
         cells_reg <= cells_next;
      end
   end

   // ---------------------------------------------
   // Read path
   // ---------------------------------------------
   // Write-only bits cannot be read back; software keeps an image
   always_comb begin
      rdata_next = 8'h00;
      if (ctrlRd) begin
         rdata_next[ewc_pkg::BUSY_POS] = busy_reg; // [R20] [R10]
      end else if (cpuBus.rd && eeOk) begin
         rdata_next = cells_reg[eeAddr]; // [R02] [R11]
      end
   end

   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_next;
      end
   end

   assign eepromBusy = busy_reg;
   assign eepromStandby = standby_reg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   a_busy_span: assert property (@(posedge clk) disable iff (!rstnSync) // [R19]
      $rose(busy_reg) |-> ##PROG_LEN !busy_reg)
      else $error("busy did not end after the programming time");

   a_busy_hold: assert property (@(posedge clk) disable iff (!rstnSync) // [R10]
      $rose(busy_reg) |-> busy_reg[*8])
      else $error("busy dropped early");

   a_ctrl_read: assert property (@(posedge clk) disable iff (!rstnSync) // [R20]
      ctrlRd |=> rdata == {6'h00, $past(busy_reg), 1'b0})
      else $error("control read shows more than busy");

   a_busy_lock: assert property (@(posedge clk) disable iff (!rstnSync) // [R18]
      busy_reg && ctrlWr |=> $stable(standby_reg) && $stable(enable_reg))
      else $error("control changed while busy");

   a_no_enable: assert property (@(posedge clk) disable iff (!rstnSync) // [R13]
      eeWr && !enable_reg && !ctrlWr |=> !busy_reg && $stable(rowMask))
      else $error("write with programming disabled had effect");

   a_start_gate: assert property (@(posedge clk) disable iff (!rstnSync) // [R17]
      ctrlWr && !busy_reg && !(enable_reg && pmode_reg) |=> !busy_reg && !pstart_reg)
      else $error("start accepted without enable and parallel mode");

   a_auto_clear: assert property (@(posedge clk) disable iff (!rstnSync) // [R04]
      $fell(busy_reg) |-> !pmode_reg && !pstart_reg && rowMask == '0)
      else $error("parallel bits survived programming end");

   a_standby_read: assert property (@(posedge clk) disable iff (!rstnSync) // [R02]
      cpuBus.rd && !ctrlRd && standby_reg |=> rdata == 8'h00)
      else $error("array readable in standby");

   a_busy_abort: assert property (@(posedge clk) disable iff (!rstnSync) // [R11]
      busy_reg && cpuBus.wr && !ctrlWr && count_reg != '0 |=> $stable(rowMask))
      else $error("write while busy reached the latches");

   a_cancel_row: assert property (@(posedge clk) disable iff (!rstnSync) // [R09]
      ctrlWr && !busy_reg && !cpuBus.wdata[ewc_pkg::PMODE_POS] |=> rowMask == '0 && !busy_reg)
      else $error("cancel did not drop the row");

   a_row_fixed: assert property (@(posedge clk) disable iff (!rstnSync) // [R07]
      latchLoad && pmode_reg && rowHeld_reg |-> eeAddr[6:3] == row_reg)
      else $error("byte loaded outside the held row");

endmodule

`default_nettype wire

/* File: test/ewc_cpu_model.sv */
// CPU core model: issues single data-space reads and writes to the controller.
// Assumes a free-running clk; requests change 2 ns after a rising edge.
`default_nettype none

module ewc_cpu_model (
   input wire logic clk,
   input wire logic busy,
   output var ewc_pkg::ewc_bus_t cpuBus
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // Bus cycles
   // ---------------------------------------------
   // Idle bus at time zero
   initial begin
      cpuBus = '0;
   end

   // One strobe cycle, taken at the next edge; released lines invert so stale values never match
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      cpuBus = '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      #2;
      cpuBus = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask

   // Software polls busy before the next array access; n counts busy cycles seen
   task automatic waitIdle(output int n);
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         #2;
         n++;
      end
   endtask
endmodule

`default_nettype wire

/* File: test/eeprom_write_control_tb.sv */
// Self-checking bench for the EEPROM write controller.
// Assumes ewc_top with a short programming cycle and the CPU model as bus master.
`default_nettype none

module eeprom_write_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // Signals and instances
   // ---------------------------------------------
   localparam int P = 10;
   localparam logic [7:0] CTRL = ewc_pkg::CTRL_ADDR;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] bank = 2'h1;
   logic [7:0] rdata;
   logic busy;
   logic standby;
   ewc_pkg::ewc_bus_t cpuBus;
   logic [7:0] expQ[$];
   logic rdPend = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'h38ca_b94c;
   logic [7:0] d[0:2];
   logic [7:0] x;
   logic [7:0] e;
   int n;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   ewc_top #(.PROG_CYCLES(P)) uut (.clk(clk), .rstn(rstn), .cpuBus(cpuBus), .dataBankSelect(bank),
      .rdata(rdata), .eepromBusy(busy), .eepromStandby(standby));
   ewc_cpu_model cpu (.clk(clk), .busy(busy), .cpuBus(cpuBus));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cpu.access(1'b1, a, v);
   endtask

   // The expectation is noted before the strobe so the monitor always finds it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      expQ.push_back(exp);
      cpu.access(1'b0, a, 8'h00);
   endtask

   task automatic busyLen(output int len);
      repeat (3) begin
         if (busy !== 1'b1) begin
            @(posedge clk);
            #2;
         end
      end
      cpu.waitIdle(len);
   endtask

   task automatic results();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Read answers arrive one edge after the strobe edge
   always @(posedge clk) begin
      if (rdPend) begin
         check(rdata, expQ.pop_front());
      end
      rdPend <= cpuBus.rd;
   end

   // Hang guard, far beyond the hundred-odd cycles the run needs
   initial begin
      #200000;
      bad_count++;
      results();
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #2;
      rstn = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      // Reset state, unmapped place and erased array
      rd(CTRL, 8'h00);
      rd(8'h80, 8'h00);
      rd(8'h05, 8'hFF);
      // Array write while programming is disabled
      wr(8'h05, 8'h5A);
      repeat (2) @(posedge clk);
      check({7'h00, busy}, 8'h00);
      rd(8'h05, 8'hFF);
      wr(CTRL, 8'h01);
      rd(CTRL, 8'h00);
      // Partial row load, a write outside the held row, then start
      for (int i = 0; i < 3; i++) d[i] = rnd();
      wr(CTRL, 8'h05);
      wr(8'h18, d[0]);
      wr(8'h1A, d[1]);
      wr(8'h1B, d[2]);
      wr(8'h20, rnd());
      wr(CTRL, 8'h0D);
      busyLen(n);
      check(8'(n), 8'(P));
      for (int a = 8'h18; a < 8'h20; a++) begin
         e = (a == 8'h18) ? d[0] : (a == 8'h1A) ? d[1] : (a == 8'h1B) ? d[2] : 8'hFF;
         rd(8'(a), e);
      end
      rd(8'h20, 8'hFF);
      // Mode bit cleared by the cycle, so start is refused
      wr(CTRL, 8'h0D);
      repeat (3) @(posedge clk);
      check({7'h00, busy}, 8'h00);
      // Cancelled row is dropped; a start on fresh latches changes nothing
      wr(8'h10, rnd());
      wr(CTRL, 8'h01);
      wr(CTRL, 8'h0D);
      repeat (3) @(posedge clk);
      check({7'h00, busy}, 8'h00);
      wr(CTRL, 8'h0D);
      busyLen(n);
      check(8'(n), 8'(P));
      rd(8'h10, 8'hFF);
      // Byte write disturbed by accesses while busy
      x = rnd();
      wr(CTRL, 8'h01);
      wr(8'h05, x);
      check({7'h00, busy}, 8'h01);
      rd(8'h06, 8'h00);
      wr(CTRL, 8'h40);
      wr(8'h05, ~x);
      cpu.waitIdle(n);
      check({7'h00, standby}, 8'h00);
      rd(8'h05, x);
      // Standby voids array access
      wr(CTRL, 8'h41);
      check({7'h00, standby}, 8'h01);
      rd(8'h05, 8'h00);
      rd(CTRL, 8'h00);
      wr(8'h05, ~x);
      wr(CTRL, 8'h01);
      check({7'h00, standby}, 8'h00);
      rd(8'h05, x);
      // Page one is separate; no page selected reads nothing
      bank = 2'h2;
      rd(8'h05, 8'hFF);
      bank = 2'h0;
      rd(8'h05, 8'h00);
      repeat (3) @(posedge clk);
      results();
   end
endmodule

`default_nettype wire
